// ==== pkg/fwg_pkg.sv ====
package fwg_pkg;

	// register offsets on the special-function register port
	localparam logic [7:0] FWG_PSC_OFS   = 8'h8f;
	localparam logic [7:0] FWG_FLK_OFS   = 8'hb7;
	localparam logic [7:0] FWG_SADDR_OFS = 8'hb6;
	localparam logic [7:0] FWG_SDATA_OFS = 8'hd1;
	localparam logic [7:0] FWG_SCTL_OFS  = 8'hc5;
	localparam logic [7:0] FWG_SKEY_OFS  = 8'hc6;

	// field positions
	localparam int FWG_WE_BIT   = 0;
	localparam int FWG_EE_BIT   = 1;
	localparam int FWG_AINC_BIT = 0;
	localparam int FWG_BWR_BIT  = 1;
	localparam int FWG_BRD_BIT  = 2;
	localparam int FWG_SEN_BIT  = 7;

	// reset values
	localparam logic [7:0] FWG_PSC_RST   = 8'h00;
	localparam logic [7:0] FWG_SCTL_RST  = 8'h01;
	localparam logic [7:0] FWG_IMAGE_RST = 8'hff;
	localparam logic [4:0] FWG_ADDR_RST  = 5'h00;

	// image geometry
	localparam int         FWG_DEPTH    = 32;
	localparam int         FWG_AW       = 5;
	localparam logic [4:0] FWG_TOP_ADDR = 5'h1f;

	// key values
	localparam logic [7:0] FWG_FKEY1 = 8'ha5;
	localparam logic [7:0] FWG_FKEY2 = 8'hf1;
	localparam logic [7:0] FWG_SKEY1 = 8'h55;
	localparam logic [7:0] FWG_SKEY2 = 8'haa;

	// lock state read codes
	localparam logic [1:0] FWG_LK_IDLE  = 2'h0;
	localparam logic [1:0] FWG_LK_FIRST = 2'h1;
	localparam logic [1:0] FWG_LK_OPEN  = 2'h2;
	localparam logic [1:0] FWG_LK_DEAD  = 2'h3;

	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_FIRST,
		KEY_OPEN,
		KEY_DEAD
	} fwg_key_state_t;

	typedef enum logic [1:0] {
		BLK_IDLE,
		BLK_READ,
		BLK_WRITE
	} fwg_blk_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} fwg_sfr_req_t;

	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  data;
	} fwg_xmove_t;

	typedef struct packed {
		logic        prog;
		logic        erase;
		logic [15:0] addr;
		logic [7:0]  data;
	} fwg_flash_cmd_t;

	typedef struct packed {
		logic       req;
		logic       we;
		logic [4:0] addr;
		logic [7:0] wdata;
	} fwg_nv_req_t;

	function automatic logic [1:0] fwg_key_code(input fwg_key_state_t st);
		case (st)
			KEY_IDLE:  fwg_key_code = FWG_LK_IDLE;
			KEY_FIRST: fwg_key_code = FWG_LK_FIRST;
			KEY_OPEN:  fwg_key_code = FWG_LK_OPEN;
			default:   fwg_key_code = FWG_LK_DEAD;
		endcase
	endfunction : fwg_key_code

	// one key write; anything out of order ends in the dead state
	function automatic fwg_key_state_t fwg_key_step(input fwg_key_state_t st,
		input logic [7:0] wdata, input logic [7:0] k1, input logic [7:0] k2);
		case (st)
			KEY_IDLE:  fwg_key_step = (wdata == k1) ? KEY_FIRST : KEY_DEAD;
			KEY_FIRST: fwg_key_step = (wdata == k2) ? KEY_OPEN : KEY_DEAD;
			default:   fwg_key_step = KEY_DEAD;
		endcase
	endfunction : fwg_key_step

endpackage : fwg_pkg

// ==== src/fwg_store_image.sv ====
`timescale 1ns/1ps
module fwg_store_image
	import fwg_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         reset_n,
	input  wire logic         addr_wr,
	input  wire logic [4:0]   addr_wdata,
	input  wire logic         data_wr,
	input  wire logic         data_rd,
	input  wire logic [7:0]   data_wdata,
	input  wire logic         auto_inc,
	input  wire logic         bulk_read_start,
	input  wire logic         bulk_write_start,
	output logic [4:0]        cur_addr,
	output logic [7:0]        cur_byte,
	output logic              bulk_busy,
	output logic              bulk_write_done,
	output fwg_nv_req_t       nv_req,
	input  wire logic [7:0]   nv_rdata,
	input  wire logic         nv_ack
);

	logic [7:0]     image_q [FWG_DEPTH];
	logic [4:0]     addr_q;
	logic [4:0]     idx_q;
	fwg_blk_state_t blk_q;
	logic           wdone_q;

	assign cur_addr        = addr_q;
	assign cur_byte        = image_q[addr_q];
	assign bulk_busy       = (blk_q != BLK_IDLE);
	assign bulk_write_done = wdone_q;

	// byte access is held off during a bulk copy so the image stays coherent
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_q <= FWG_ADDR_RST;
		end else if (addr_wr) begin
			addr_q <= addr_wdata;
		end else if (auto_inc && !bulk_busy && (data_wr || data_rd)) begin
			addr_q <= (addr_q == FWG_TOP_ADDR) ? FWG_ADDR_RST : addr_q + 5'h01;
		end
	end

	generate
		for (genvar i = 0; i < FWG_DEPTH; i++) begin : g_byte
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					image_q[i] <= FWG_IMAGE_RST;
				end else if (blk_q == BLK_READ && nv_ack && idx_q == 5'(i)) begin
					image_q[i] <= nv_rdata;
				end else if (data_wr && !bulk_busy && addr_q == 5'(i)) begin
					image_q[i] <= data_wdata;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			blk_q   <= BLK_IDLE;
			idx_q   <= FWG_ADDR_RST;
			wdone_q <= 1'b0;
		end else begin
			wdone_q <= 1'b0;
			case (blk_q)
				BLK_IDLE: begin
					idx_q <= FWG_ADDR_RST;
					if (bulk_read_start) begin
						blk_q <= BLK_READ;
					end else if (bulk_write_start) begin
						blk_q <= BLK_WRITE;
					end
				end
				BLK_READ, BLK_WRITE: begin
					if (nv_ack) begin
						idx_q <= idx_q + 5'h01;
						if (idx_q == FWG_TOP_ADDR) begin
							blk_q   <= BLK_IDLE;
							wdone_q <= (blk_q == BLK_WRITE);
						end
					end
				end
				default: blk_q <= BLK_IDLE;
			endcase
		end
	end

	always_comb begin
		nv_req.req   = bulk_busy;
		nv_req.we    = (blk_q == BLK_WRITE);
		nv_req.addr  = idx_q;
		nv_req.wdata = image_q[idx_q];
	end

endmodule : fwg_store_image

// ==== src/fwg_guard.sv ====
`timescale 1ns/1ps
// Summary of operation
// - write enable steers external writes to flash
// - erase plus write enable erases page
// - two key writes unlock flash modification
// - one completed operation relocks flash
// - wrong key write locks until reset
// - modify attempt while locked with supply monitor on locks until reset
// - key register reads lock state low bits
// - control upper six bits read zero
// - store access needs store enable set
// - address then data write updates image
// - data read returns image byte at address
// - auto increment advances address per access
// - address wraps from top to zero
// - bulk read copies nonvolatile into image
// - bulk write copies image to nonvolatile
// - bulk write refused without store unlock
// - store keys 55 then aa, relock
// - bad store key or attempt locks
// - supply monitor off gives error reset
module fwg_guard
	import fwg_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         reset_n,
	input  fwg_sfr_req_t      sfr_req,
	output logic [7:0]        sfr_rdata,
	input  fwg_xmove_t        xmove_req,
	output fwg_xmove_t        xram_cmd,
	output fwg_flash_cmd_t    flash_cmd,
	input  wire logic         flash_done,
	output logic              flash_busy,
	input  wire logic         supply_mon_en,
	input  wire logic         supply_mon_rst_en,
	output logic              flash_error_reset,
	output fwg_nv_req_t       nv_req,
	input  wire logic [7:0]   nv_rdata,
	input  wire logic         nv_ack
);

	logic           write_en_q;
	logic           erase_en_q;
	fwg_key_state_t fkey_q;
	logic           fbusy_q;
	fwg_flash_cmd_t fcmd_q;
	fwg_xmove_t     xram_q;
	logic           ferr_q;

	logic           store_en_q;
	logic           auto_inc_q;
	fwg_key_state_t skey_q;
	logic [7:0]     rdata_q;

	logic           wr_psc;
	logic           wr_flk;
	logic           wr_saddr;
	logic           wr_sdata;
	logic           rd_sdata;
	logic           wr_sctl;
	logic           wr_skey;
	logic           attempt;
	logic           supply_ok;
	logic           bulk_rd_go;
	logic           bulk_wr_req;
	logic           bulk_wr_go;

	logic [4:0]     cur_addr;
	logic [7:0]     cur_byte;
	logic           bulk_busy;
	logic           bulk_write_done;

	function automatic logic sfr_hit(input fwg_sfr_req_t r, input logic [7:0] ofs);
		sfr_hit = (r.addr == ofs);
	endfunction : sfr_hit

	// register decode
	assign wr_psc   = sfr_req.wr && sfr_hit(sfr_req, FWG_PSC_OFS);
	assign wr_flk   = sfr_req.wr && sfr_hit(sfr_req, FWG_FLK_OFS);
	assign wr_sctl  = sfr_req.wr && sfr_hit(sfr_req, FWG_SCTL_OFS);
	assign wr_skey  = sfr_req.wr && sfr_hit(sfr_req, FWG_SKEY_OFS);
	// store address and data are dead while the store is disabled
	assign wr_saddr = sfr_req.wr && store_en_q && sfr_hit(sfr_req, FWG_SADDR_OFS);
	assign wr_sdata = sfr_req.wr && store_en_q && sfr_hit(sfr_req, FWG_SDATA_OFS);
	assign rd_sdata = sfr_req.rd && store_en_q && sfr_hit(sfr_req, FWG_SDATA_OFS);

	assign attempt   = xmove_req.wr && write_en_q;
	assign supply_ok = supply_mon_en && supply_mon_rst_en;

	// bulk triggers act only with the store enabled in the same write
	assign bulk_rd_go  = wr_sctl && sfr_req.wdata[FWG_SEN_BIT] && sfr_req.wdata[FWG_BRD_BIT]
		&& !bulk_busy;
	assign bulk_wr_req = wr_sctl && sfr_req.wdata[FWG_SEN_BIT] && sfr_req.wdata[FWG_BWR_BIT]
		&& !sfr_req.wdata[FWG_BRD_BIT] && !bulk_busy;
	assign bulk_wr_go  = bulk_wr_req && (skey_q == KEY_OPEN);

	// program store enables; only the two low bits are kept
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			write_en_q <= FWG_PSC_RST[FWG_WE_BIT];
			erase_en_q <= FWG_PSC_RST[FWG_EE_BIT];
		end else if (wr_psc) begin
			write_en_q <= sfr_req.wdata[FWG_WE_BIT];
			erase_en_q <= sfr_req.wdata[FWG_EE_BIT];
		end
	end

	// flash key machine; completion outranks an attempt, which outranks a key write
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			fkey_q <= KEY_IDLE;
		end else if (fbusy_q && flash_done) begin
			fkey_q <= (fkey_q == KEY_DEAD) ? KEY_DEAD : KEY_IDLE;
		end else if (attempt && supply_ok && (fkey_q != KEY_OPEN || fbusy_q)) begin
			fkey_q <= KEY_DEAD;
		end else if (wr_flk) begin
			fkey_q <= fwg_key_step(fkey_q, sfr_req.wdata, FWG_FKEY1, FWG_FKEY2);
		end
	end

	// one operation in flight; the key state shows open until it completes, unless a further attempt or key write sends it dead first
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			fbusy_q <= 1'b0;
		end else if (fbusy_q && flash_done) begin
			fbusy_q <= 1'b0;
		end else if (attempt && supply_ok && fkey_q == KEY_OPEN) begin
			fbusy_q <= 1'b1;
		end
	end

	assign flash_busy = fbusy_q;

	// flash command pulse
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			fcmd_q <= '0;
		end else begin
			fcmd_q.prog  <= 1'b0;
			fcmd_q.erase <= 1'b0;
			if (attempt && supply_ok && fkey_q == KEY_OPEN && !fbusy_q) begin
				fcmd_q.erase <= erase_en_q;
				fcmd_q.prog  <= !erase_en_q;
				fcmd_q.addr  <= xmove_req.addr;
				// erase ignores the data byte, so it is not carried
				fcmd_q.data  <= erase_en_q ? FWG_IMAGE_RST : xmove_req.data;
			end
		end
	end

	assign flash_cmd = fcmd_q;

	// supply guard: modification never reaches flash with the monitor off
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ferr_q <= 1'b0;
		end else begin
			ferr_q <= attempt && !supply_ok;
		end
	end

	assign flash_error_reset = ferr_q;

	// external data memory path
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			xram_q <= '0;
		end else begin
			xram_q.wr <= 1'b0;
			if (xmove_req.wr && !write_en_q) begin
				xram_q <= xmove_req;
			end
		end
	end

	assign xram_cmd = xram_q;

	// store control bits; triggers are not stored, they read back as busy
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			store_en_q <= FWG_SCTL_RST[FWG_SEN_BIT];
			auto_inc_q <= FWG_SCTL_RST[FWG_AINC_BIT];
		end else if (wr_sctl) begin
			store_en_q <= sfr_req.wdata[FWG_SEN_BIT];
			auto_inc_q <= sfr_req.wdata[FWG_AINC_BIT];
		end
	end

	// store key machine; a refused bulk write or bad key locks until reset
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			skey_q <= KEY_IDLE;
		end else if (bulk_write_done && skey_q != KEY_DEAD) begin
			skey_q <= KEY_IDLE;
		end else if (bulk_wr_req && skey_q != KEY_OPEN) begin
			skey_q <= KEY_DEAD;
		end else if (bulk_wr_go) begin
			skey_q <= KEY_OPEN;
		end else if (wr_skey) begin
			skey_q <= fwg_key_step(skey_q, sfr_req.wdata, FWG_SKEY1, FWG_SKEY2);
		end
	end

	fwg_store_image u_image (
		.ref_clk          (ref_clk),
		.reset_n          (reset_n),
		.addr_wr          (wr_saddr),
		.addr_wdata       (sfr_req.wdata[FWG_AW-1:0]),
		.data_wr          (wr_sdata),
		.data_rd          (rd_sdata),
		.data_wdata       (sfr_req.wdata),
		.auto_inc         (auto_inc_q),
		.bulk_read_start  (bulk_rd_go),
		.bulk_write_start (bulk_wr_go),
		.cur_addr         (cur_addr),
		.cur_byte         (cur_byte),
		.bulk_busy        (bulk_busy),
		.bulk_write_done  (bulk_write_done),
		.nv_req           (nv_req),
		.nv_rdata         (nv_rdata),
		.nv_ack           (nv_ack)
	);

	// read data is registered; unmapped offsets and store address and data with the store disabled read zero
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 8'h00;
		end else if (sfr_req.rd) begin
			case (sfr_req.addr)
				FWG_PSC_OFS:   rdata_q <= {6'h00, erase_en_q, write_en_q};
				FWG_FLK_OFS:   rdata_q <= {6'h00, fwg_key_code(fkey_q)};
				FWG_SKEY_OFS:  rdata_q <= {6'h00, fwg_key_code(skey_q)};
				FWG_SCTL_OFS:  rdata_q <= {store_en_q, 4'h0, bulk_busy && nv_req.we == 1'b0,
					bulk_busy && nv_req.we, auto_inc_q};
				FWG_SADDR_OFS: rdata_q <= store_en_q ? {3'h0, cur_addr} : 8'h00;
				FWG_SDATA_OFS: rdata_q <= (store_en_q && !bulk_busy) ? cur_byte : 8'h00;
				default:       rdata_q <= 8'h00;
			endcase
		end
	end

	assign sfr_rdata = rdata_q;

endmodule : fwg_guard

// ==== testbench/fwg_guard_assertions.sv ====
`timescale 1ns/1ps
module fwg_guard_chk
	import fwg_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  fwg_sfr_req_t    sfr_req,
	input  wire logic [7:0] sfr_rdata,
	input  fwg_xmove_t      xmove_req,
	input  fwg_xmove_t      xram_cmd,
	input  fwg_flash_cmd_t  flash_cmd,
	input  wire logic       flash_done,
	input  wire logic       flash_busy,
	input  wire logic       supply_mon_en,
	input  wire logic       supply_mon_rst_en,
	input  wire logic       flash_error_reset,
	input  fwg_nv_req_t     nv_req,
	input  wire logic [7:0] nv_rdata,
	input  wire logic       nv_ack
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	logic cmd_any;
	assign cmd_any = flash_cmd.prog | flash_cmd.erase;
	a_erase_data_ones: assert property (flash_cmd.erase |->
		flash_cmd.data == 8'hff && !flash_cmd.prog) else $error("erase command malformed");
	a_cmd_has_cause: assert property (cmd_any |-> $past(xmove_req.wr) && flash_busy
		&& flash_cmd.addr == $past(xmove_req.addr)) else $error("flash command without attempt");
	a_xram_has_cause: assert property (xram_cmd.wr |-> $past(xmove_req.wr) && !cmd_any
		&& xram_cmd.addr == $past(xmove_req.addr)) else $error("xram write wrong");
	a_err_needs_off: assert property (flash_error_reset |-> $past(xmove_req.wr)
		&& !cmd_any && !($past(supply_mon_en) && $past(supply_mon_rst_en)))
		else $error("bad error reset");
	a_busy_release: assert property (flash_busy && flash_done |=> !flash_busy)
		else $error("busy held after done");
	a_busy_no_cmd: assert property (flash_busy && !flash_done |=> !cmd_any)
		else $error("command while busy");
	a_nv_index_step: assert property (nv_req.req && nv_ack && nv_req.addr != 5'h1f
		|=> nv_req.req && nv_req.addr == $past(nv_req.addr) + 5'h01)
		else $error("copy index step wrong");
	a_nv_copy_end: assert property (nv_req.req && nv_ack && nv_req.addr == 5'h1f |=> !nv_req.req)
		else $error("copy does not end");
	a_ctl_upper_zero: assert property ($past(sfr_req.rd)
		&& $past(sfr_req.addr) == FWG_PSC_OFS |-> sfr_rdata[7:2] == 6'h00)
		else $error("control upper bits set");
endmodule : fwg_guard_chk

bind fwg_guard fwg_guard_chk i_chk (.ref_clk, .reset_n, .sfr_req, .sfr_rdata, .xmove_req,
	.xram_cmd, .flash_cmd, .flash_done, .flash_busy, .supply_mon_en, .supply_mon_rst_en,
	.flash_error_reset, .nv_req, .nv_rdata, .nv_ack);

// ==== testbench/fwg_mem_model.sv ====
`timescale 1ns/1ps
module fwg_mem_model
	import fwg_pkg::*;
#(
	parameter int DLY = 4
)
(
	input  wire logic      ref_clk,
	input  wire logic      reset_n,
	input  fwg_flash_cmd_t flash_cmd,
	output logic           flash_done,
	input  fwg_nv_req_t    nv_req,
	output logic [7:0]     nv_rdata,
	output logic           nv_ack
);
	logic [7:0] mem [32];
	int         cnt;
	// slow flash array: done comes DLY cycles after a command
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 0;
			flash_done <= 1'b0;
		end else begin
			if (flash_cmd.prog | flash_cmd.erase) cnt <= DLY;
			else if (cnt > 0) cnt <= cnt - 1;
			flash_done <= (cnt == 1);
		end
	end
	// ack every other cycle; data toggles when not acked so stale bytes show
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			nv_ack <= 1'b0;
			nv_rdata <= 8'h00;
			for (int i = 0; i < 32; i++) mem[i] <= 8'h40 + 8'(i);
		end else begin
			nv_ack <= nv_req.req && !nv_ack;
			nv_rdata <= (nv_req.req && !nv_ack) ? mem[nv_req.addr] : ~nv_rdata;
			if (nv_ack && nv_req.req && nv_req.we) mem[nv_req.addr] <= nv_req.wdata;
		end
	end
endmodule : fwg_mem_model

// ==== testbench/flash_write_guard_and_eeprom_emu_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("[ERR] %s exp %h got %h", nm, e, g); \
	end \
end
module flash_write_guard_and_eeprom_emu_tb
	import fwg_pkg::*;
;
	logic           ref_clk = 1'b0;
	logic           reset_n = 1'b0;
	fwg_sfr_req_t   sfr = '0;
	fwg_xmove_t     xmv = '0;
	logic           smon = 1'b1;
	logic           smr = 1'b1;
	logic [7:0]     rdata;
	logic [7:0]     q;
	fwg_xmove_t     xram_cmd;
	fwg_flash_cmd_t flash_cmd;
	fwg_nv_req_t    nv_req;
	logic           flash_done;
	logic           flash_busy;
	logic           ferr;
	logic           nv_ack;
	logic [7:0]     nv_rdata;
	int             fails = 0;
	int             n_compared = 0;
	int             cyc = 0;
	always #5 ref_clk = ~ref_clk;
	fwg_guard i_dut (.ref_clk, .reset_n, .sfr_req(sfr), .sfr_rdata(rdata), .xmove_req(xmv),
		.xram_cmd, .flash_cmd, .flash_done, .flash_busy, .supply_mon_en(smon),
		.supply_mon_rst_en(smr), .flash_error_reset(ferr), .nv_req, .nv_rdata, .nv_ack);
	fwg_mem_model i_mem (.ref_clk, .reset_n, .flash_cmd, .flash_done, .nv_req, .nv_rdata,
		.nv_ack);
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	// whole run is a few hundred cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			final_report;
		end
	end
	task automatic rst;
		reset_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
	endtask : rst
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfr <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge ref_clk);
		sfr.wr <= 1'b0;
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		sfr <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge ref_clk);
		sfr.rd <= 1'b0;
		#1 q = rdata;
		`CHK("sfr_rdata", e, q)
	endtask : rc
	task automatic xm(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		xmv <= '{wr: 1'b1, addr: a, data: d};
		@(posedge ref_clk);
		xmv.wr <= 1'b0;
		#1;
	endtask : xm
	task automatic idle;
		int n;
		n = 0;
		#1;
		while ((flash_busy !== 1'b0 || nv_req.req !== 1'b0) && n < 300) begin
			@(posedge ref_clk);
			#1 n++;
		end
		if (n == 300) fails++;
	endtask : idle
	initial begin
		rst;
		rc(FWG_PSC_OFS, 8'h00);
		rc(FWG_FLK_OFS, 8'h00);
		rc(FWG_SDATA_OFS, 8'h00);
		xm(16'h1234, 8'h5a);
		`CHK("xram_cmd", {1'b1, 16'h1234, 8'h5a}, xram_cmd)
		`CHK("flash_cmd", 1'b0, flash_cmd.prog | flash_cmd.erase)
		wr(FWG_PSC_OFS, 8'hfd);
		rc(FWG_PSC_OFS, 8'h01);
		for (int i = 0; i < 2; i++) begin
			wr(FWG_FLK_OFS, FWG_FKEY1);
			rc(FWG_FLK_OFS, 8'h01);
			wr(FWG_FLK_OFS, FWG_FKEY2);
			rc(FWG_FLK_OFS, 8'h02);
			// erase the page first, then program a byte into it
			wr(FWG_PSC_OFS, {6'h00, ~i[0], 1'b1});
			xm(16'h0345, 8'h12);
			`CHK("flash_cmd", {i[0], ~i[0], 16'h0345, i[0] ? 8'h12 : 8'hff}, flash_cmd)
			`CHK("flash_busy", 1'b1, flash_busy)
			idle;
			rc(FWG_FLK_OFS, 8'h00);
		end
		wr(FWG_FLK_OFS, FWG_FKEY1);
		wr(FWG_FLK_OFS, FWG_FKEY2);
		for (int i = 0; i < 2; i++) begin
			{smon, smr} <= i[0] ? 2'b01 : 2'b10;
			xm(16'h0100, 8'h00);
			`CHK("flash_error_reset", 1'b1, ferr)
			`CHK("flash_cmd", 1'b0, flash_cmd.prog | flash_cmd.erase)
			@(posedge ref_clk);
			{smon, smr} <= 2'b11;
			rc(FWG_FLK_OFS, 8'h02);
		end
		// second attempt lands while the first program is still busy
		xm(16'h0400, 8'h00);
		xm(16'h0401, 8'h00);
		`CHK("flash_cmd", 1'b0, flash_cmd.prog | flash_cmd.erase)
		idle;
		rc(FWG_FLK_OFS, 8'h03);
		wr(FWG_SCTL_OFS, 8'h85);
		idle;
		rc(FWG_SCTL_OFS, 8'h81);
		wr(FWG_SADDR_OFS, 8'h05);
		rc(FWG_SDATA_OFS, 8'h45);
		wr(FWG_SADDR_OFS, 8'h1e);
		for (int i = 1; i < 4; i++) wr(FWG_SDATA_OFS, 8'(i * 17));
		rc(FWG_SADDR_OFS, 8'h01);
		wr(FWG_SADDR_OFS, 8'h1f);
		rc(FWG_SDATA_OFS, 8'h22);
		rc(FWG_SDATA_OFS, 8'h33);
		wr(FWG_SKEY_OFS, FWG_SKEY1);
		wr(FWG_SKEY_OFS, FWG_SKEY2);
		rc(FWG_SKEY_OFS, 8'h02);
		wr(FWG_SCTL_OFS, 8'h82);
		idle;
		`CHK("nv_image", {8'h11, 8'h33, 8'h46}, {i_mem.mem[30], i_mem.mem[0], i_mem.mem[6]})
		rc(FWG_SKEY_OFS, 8'h00);
		wr(FWG_SCTL_OFS, 8'h82);
		#1 `CHK("nv_req", 1'b0, nv_req.req)
		rc(FWG_SKEY_OFS, 8'h03);
		rst;
		rc(FWG_FLK_OFS, 8'h00);
		rc(FWG_PSC_OFS, 8'h00);
		rc(FWG_SCTL_OFS, 8'h01);
		wr(FWG_FLK_OFS, 8'h12);
		rc(FWG_FLK_OFS, 8'h03);
		rst;
		wr(FWG_FLK_OFS, FWG_FKEY1);
		wr(FWG_FLK_OFS, FWG_FKEY1);
		rc(FWG_FLK_OFS, 8'h03);
		// modify attempt with no key written at all
		rst;
		wr(FWG_PSC_OFS, 8'h01);
		xm(16'h0200, 8'h77);
		`CHK("flash_cmd", 1'b0, flash_cmd.prog | flash_cmd.erase)
		rc(FWG_FLK_OFS, 8'h03);
		final_report;
	end
endmodule : flash_write_guard_and_eeprom_emu_tb
